// ---- auto_reclose_general_control.sv ----
/*
  general control and status of the auto_reclose sequencer: enabling, object select,
  lockout and reclaim countdowns, locked state and its release, status and interrupt.
  assumes a shot engine outside that reports requests, shots, success and its own timers.
*/
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module auto_reclose_general_control #(
  parameter int unsigned TICK_CYCLES = reclose_ctrl_pkg::TICK_CYCLES,
  parameter int unsigned NUM_GROUPS  = 4
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rd_data_o,
  output logic             irq_o,
  // device inputs
  input  wire logic [1:0]  setting_group_i,
  input  wire logic        reclose_enable_input_i,
  input  wire logic        block_i,
  input  wire logic        object_fault_i,
  input  wire logic        lock_input_i,
  input  wire logic        lock_reset_i,
  input  wire logic        manual_close_i,
  input  wire logic        any_close_cmd_i,
  input  wire logic        final_trip_i,
  input  wire logic        reclose_success_i,
  input  wire logic [4:0]  reclose_request_i,
  input  wire logic [4:0]  shot_running_i,
  input  wire logic        shot_clear_i,
  input  wire logic [2:0]  shot_timer_kind_i,
  input  wire logic [18:0] shot_timer_value_i,
  // outputs to shot engine and object control
  output logic             sequence_start_o,
  output logic             open_cmd_o,
  output logic      [4:0]  object_sel_o,
  output logic      [31:0] status_o,
  output logic      [2:0]  timer_kind_o,
  output logic      [18:0] timer_value_o
);

  localparam int unsigned TW  = reclose_ctrl_pkg::TIME_W;
  localparam int unsigned CW  = reclose_ctrl_pkg::CFG_W;
  localparam int unsigned EW  = reclose_ctrl_pkg::EV_W;
  localparam int unsigned DVW = $clog2(TICK_CYCLES);
  localparam logic [DVW-1:0] DIV_LAST = DVW'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////
  // group register decode
  function automatic logic grp_hit(input logic [7:0] a);
    logic [3:0] g;
    g = a[7:4] - reclose_ctrl_pkg::GRP_BASE_HI;
    grp_hit = (a[7:4] >= reclose_ctrl_pkg::GRP_BASE_HI) && (32'(g) < NUM_GROUPS)
              && (a[3:2] <= reclose_ctrl_pkg::GRP_RCLM_SEL) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [1:0] grp_idx(input logic [7:0] a);
    logic [3:0] g;
    g = a[7:4] - reclose_ctrl_pkg::GRP_BASE_HI;
    grp_idx = g[1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // tick divider
  logic [DVW-1:0] div_q;
  logic [DVW-1:0] div_d;
  logic           tick_q;
  logic           tick_d;

  always_comb begin
    tick_d = (div_q == DIV_LAST);
    div_d  = tick_d ? '0 : div_q + 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings registers
  logic [1:0]    ctrl_q;
  logic [1:0]    ctrl_d;
  logic [CW-1:0] cfg_q  [NUM_GROUPS];
  logic [CW-1:0] cfg_d  [NUM_GROUPS];
  logic [TW-1:0] lock_q [NUM_GROUPS];
  logic [TW-1:0] lock_d [NUM_GROUPS];
  logic [TW-1:0] rclm_q [NUM_GROUPS];
  logic [TW-1:0] rclm_d [NUM_GROUPS];
  logic [EW-1:0] mask_q;
  logic [EW-1:0] mask_d;
  logic [1:0]    wg;

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    cfg_d  = cfg_q;
    lock_d = lock_q;
    rclm_d = rclm_q;
    wg     = grp_idx(addr_i);
    if (wr_i && addr_i == reclose_ctrl_pkg::CTRL_ADDR) begin
      ctrl_d = wr_data_i[1:0];
    end
    if (wr_i && addr_i == reclose_ctrl_pkg::MASK_ADDR) begin
      mask_d = wr_data_i[EW-1:0];
    end
    if (wr_i && grp_hit(addr_i)) begin
      unique case (addr_i[3:2])
        reclose_ctrl_pkg::GRP_CFG_SEL:  cfg_d[wg]  = wr_data_i[CW-1:0];
        reclose_ctrl_pkg::GRP_LOCK_SEL: lock_d[wg] = wr_data_i[TW-1:0];
        reclose_ctrl_pkg::GRP_RCLM_SEL: rclm_d[wg] = wr_data_i[TW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ctrl_q <= '0;
      mask_q <= '0;
      for (int i = 0; i < NUM_GROUPS; i++) begin
        cfg_q[i]  <= reclose_ctrl_pkg::CFG_RST;
        lock_q[i] <= reclose_ctrl_pkg::LOCKOUT_RST;
        rclm_q[i] <= reclose_ctrl_pkg::RECLAIM_RST;
      end
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      cfg_q  <= cfg_d;
      lock_q <= lock_d;
      rclm_q <= rclm_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // live view of the active group
  logic [CW-1:0] act_cfg;
  logic [TW-1:0] act_lock;
  logic [TW-1:0] act_rclm;
  logic          enabled;
  logic          any_req;

  always_comb begin
    act_cfg  = cfg_q[setting_group_i];
    act_lock = lock_q[setting_group_i];
    act_rclm = rclm_q[setting_group_i];
    enabled  = ctrl_q[reclose_ctrl_pkg::CTRL_MODE_BIT]
               && act_cfg[reclose_ctrl_pkg::CFG_EN_BIT]
               && (!ctrl_q[reclose_ctrl_pkg::CTRL_EXT_BIT] || reclose_enable_input_i);
    any_req  = |reclose_request_i;
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer state and countdown
  reclose_ctrl_pkg::state_t state_q;
  reclose_ctrl_pkg::state_t state_d;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] timer_d;
  logic          start_d;
  logic          open_d;
  logic [EW-1:0] ev_set;
  logic          release_lock;

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    start_d = 1'b0;
    open_d  = 1'b0;
    ev_set  = '0;
    release_lock = lock_reset_i
                   || (act_cfg[reclose_ctrl_pkg::CFG_RST_BIT] && any_close_cmd_i);
    if ((state_q == reclose_ctrl_pkg::ST_LOCKOUT || state_q == reclose_ctrl_pkg::ST_RECLAIM)
        && tick_q && timer_q != '0) begin
      timer_d = timer_q - 1'b1;
    end
    unique case (state_q)
      reclose_ctrl_pkg::ST_INHIBIT: begin
        if (enabled && !block_i && !object_fault_i) begin
          state_d = reclose_ctrl_pkg::ST_READY;
          ev_set[reclose_ctrl_pkg::EV_READY] = 1'b1;
        end
      end
      reclose_ctrl_pkg::ST_READY: begin
        if (manual_close_i) begin
          state_d = reclose_ctrl_pkg::ST_RECLAIM;
          timer_d = act_rclm;
        end else if (any_req) begin
          state_d = reclose_ctrl_pkg::ST_RUNNING;
          start_d = 1'b1;
        end
      end
      reclose_ctrl_pkg::ST_RUNNING: begin
        if (reclose_success_i) begin
          ev_set[reclose_ctrl_pkg::EV_SUCCESS] = 1'b1;
          if (act_cfg[reclose_ctrl_pkg::CFG_GEN_BIT]) begin
            state_d = reclose_ctrl_pkg::ST_RECLAIM;
            timer_d = act_rclm;
          end else if (act_lock == '0) begin
            state_d = reclose_ctrl_pkg::ST_READY;
            ev_set[reclose_ctrl_pkg::EV_READY] = 1'b1;
          end else begin
            state_d = reclose_ctrl_pkg::ST_LOCKOUT;
            timer_d = act_lock;
          end
        end
      end
      reclose_ctrl_pkg::ST_LOCKOUT: begin
        if (any_req) begin
          state_d = reclose_ctrl_pkg::ST_LOCKED;
          open_d  = 1'b1;
          ev_set[reclose_ctrl_pkg::EV_OPEN] = 1'b1;
          ev_set[reclose_ctrl_pkg::EV_LOCKED] = 1'b1;
        end else if (timer_q == '0) begin
          state_d = reclose_ctrl_pkg::ST_READY;
          ev_set[reclose_ctrl_pkg::EV_READY] = 1'b1;
        end
      end
      reclose_ctrl_pkg::ST_RECLAIM: begin
        if (any_req) begin
          state_d = reclose_ctrl_pkg::ST_LOCKED;
          ev_set[reclose_ctrl_pkg::EV_LOCKED] = 1'b1;
        end else if (timer_q == '0) begin
          state_d = reclose_ctrl_pkg::ST_READY;
          ev_set[reclose_ctrl_pkg::EV_READY] = 1'b1;
        end
      end
      reclose_ctrl_pkg::ST_LOCKED: begin
        if (release_lock && !final_trip_i && !lock_input_i) begin
          state_d = reclose_ctrl_pkg::ST_INHIBIT;
        end
      end
      default: state_d = reclose_ctrl_pkg::ST_INHIBIT;
    endcase
    // higher priority overrides
    if (state_q != reclose_ctrl_pkg::ST_LOCKED && (final_trip_i || lock_input_i)) begin
      state_d = reclose_ctrl_pkg::ST_LOCKED;
      start_d = 1'b0;
      ev_set[reclose_ctrl_pkg::EV_LOCKED] = 1'b1;
    end else if (state_q != reclose_ctrl_pkg::ST_LOCKED
                 && (!enabled || block_i || object_fault_i)) begin
      state_d = reclose_ctrl_pkg::ST_INHIBIT;
      start_d = 1'b0;
      open_d  = 1'b0;
      ev_set  = '0;
    end
    if (state_d != reclose_ctrl_pkg::ST_LOCKOUT && state_d != reclose_ctrl_pkg::ST_RECLAIM) begin
      timer_d = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= reclose_ctrl_pkg::ST_INHIBIT;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // events and interrupt
  logic [EW-1:0] event_q;
  logic [EW-1:0] event_d;
  logic          irq_d;

  always_comb begin
    event_d = event_q;
    if (wr_i && addr_i == reclose_ctrl_pkg::EVENT_ADDR) begin
      event_d = event_d & ~wr_data_i[EW-1:0];
    end
    event_d = event_d | ev_set;
    irq_d   = |(event_d & mask_q);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      event_q <= '0;
      irq_o   <= 1'b0;
    end else begin
      event_q <= event_d;
      irq_o   <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status, timer view and command outputs
  logic [31:0]   status_d;
  logic [2:0]    kind_d;
  logic [TW-1:0] value_d;
  logic [4:0]    obj_d;
  logic [CW-1:0] rcfg;

  always_comb begin
    status_d = '0;
    status_d[0] = (state_d == reclose_ctrl_pkg::ST_INHIBIT);
    status_d[1] = (state_d == reclose_ctrl_pkg::ST_READY);
    status_d[2] = (state_d == reclose_ctrl_pkg::ST_LOCKED);
    status_d[3] = (state_d == reclose_ctrl_pkg::ST_RUNNING);
    status_d[4] = (state_d != reclose_ctrl_pkg::ST_RUNNING);
    status_d[5] = (state_d == reclose_ctrl_pkg::ST_LOCKOUT);
    status_d[6] = (state_d == reclose_ctrl_pkg::ST_RECLAIM);
    status_d[11:7]  = reclose_request_i;
    status_d[16:12] = shot_running_i;
    status_d[17] = shot_clear_i;
    kind_d  = reclose_ctrl_pkg::TK_NONE;
    value_d = '0;
    unique case (state_d)
      reclose_ctrl_pkg::ST_LOCKOUT: begin
        kind_d  = reclose_ctrl_pkg::TK_LOCKOUT;
        value_d = timer_d;
      end
      reclose_ctrl_pkg::ST_RECLAIM: begin
        kind_d  = reclose_ctrl_pkg::TK_RESET;
        value_d = timer_d;
      end
      reclose_ctrl_pkg::ST_RUNNING: begin
        kind_d  = shot_timer_kind_i;
        value_d = shot_timer_value_i;
      end
      default: ;
    endcase
    obj_d = '0;
    if (32'(act_cfg[reclose_ctrl_pkg::CFG_OBJ_LSB +: reclose_ctrl_pkg::CFG_OBJ_W])
        < reclose_ctrl_pkg::NUM_OBJ) begin
      obj_d[act_cfg[reclose_ctrl_pkg::CFG_OBJ_LSB +: reclose_ctrl_pkg::CFG_OBJ_W]] = 1'b1;
    end else begin
      obj_d[0] = 1'b1;
    end
    status_d[18] = (kind_d != reclose_ctrl_pkg::TK_NONE);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_o         <= '0;
      timer_kind_o     <= reclose_ctrl_pkg::TK_NONE;
      timer_value_o    <= '0;
      object_sel_o     <= '0;
      sequence_start_o <= 1'b0;
      open_cmd_o       <= 1'b0;
    end else begin
      status_o         <= status_d;
      timer_kind_o     <= kind_d;
      timer_value_o    <= value_d;
      object_sel_o     <= obj_d;
      sequence_start_o <= start_d;
      open_cmd_o       <= open_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read
  logic [31:0] rd_d;

  always_comb begin
    rd_d = '0;
    rcfg = cfg_q[grp_idx(addr_i)];
    if (rd_i) begin
      if (grp_hit(addr_i)) begin
        unique case (addr_i[3:2])
          reclose_ctrl_pkg::GRP_CFG_SEL:  rd_d = 32'(rcfg);
          reclose_ctrl_pkg::GRP_LOCK_SEL: rd_d = 32'(lock_q[grp_idx(addr_i)]);
          reclose_ctrl_pkg::GRP_RCLM_SEL: rd_d = 32'(rclm_q[grp_idx(addr_i)]);
          default: ;
        endcase
      end else begin
        unique case (addr_i)
          reclose_ctrl_pkg::CTRL_ADDR:   rd_d = 32'(ctrl_q);
          reclose_ctrl_pkg::STATUS_ADDR: rd_d = status_o;
          reclose_ctrl_pkg::TVALUE_ADDR: rd_d = 32'(timer_value_o);
          reclose_ctrl_pkg::TKIND_ADDR:  rd_d = 32'(timer_kind_o);
          reclose_ctrl_pkg::EVENT_ADDR:  rd_d = 32'(event_q);
          reclose_ctrl_pkg::MASK_ADDR:   rd_d = 32'(mask_q);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_d;
    end
  end

endmodule

`default_nettype wire

// ---- reclose_ctrl_asserts.sv ----
/*
  port assertions of auto_reclose_general_control.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module reclose_ctrl_asserts (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // register port
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  // device inputs
  input wire logic        lock_input_i,
  input wire logic        lock_reset_i,
  input wire logic        any_close_cmd_i,
  input wire logic        final_trip_i,
  // outputs
  input wire logic        sequence_start_o,
  input wire logic        open_cmd_o,
  input wire logic [4:0]  object_sel_o,
  input wire logic [31:0] status_o,
  input wire logic [2:0]  timer_kind_o,
  input wire logic [18:0] timer_value_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not zero outside a read");
  obj_onehot_a: assert property (!$past(reset_i) |-> $onehot(object_sel_o))
    else $error("object select not one-hot");
  trip_lock_a: assert property (final_trip_i || lock_input_i |=> status_o[2])
    else $error("lock cause did not lock");
  lock_hold_a: assert property (
    status_o[2] && !lock_reset_i && !any_close_cmd_i |=> status_o[2])
    else $error("locked released without reset");
  open_lock_a: assert property (open_cmd_o |-> status_o[2] && $past(status_o[5]))
    else $error("open command outside lockout");
  start_ready_a: assert property (
    sequence_start_o |-> status_o[3] && $past(status_o[1]))
    else $error("start not from ready");
  lock_kind_a: assert property (
    status_o[5] |-> timer_kind_o == reclose_ctrl_pkg::TK_LOCKOUT)
    else $error("lockout with wrong timer kind");
  reclaim_kind_a: assert property (
    status_o[6] |-> timer_kind_o == reclose_ctrl_pkg::TK_RESET)
    else $error("reclaim with wrong timer kind");
  lock_step_a: assert property (
    status_o[5] && $past(status_o[5]) && timer_value_o != $past(timer_value_o)
    |-> timer_value_o == $past(timer_value_o) - 19'h1)
    else $error("lockout count skipped");
  ready_excl_a: assert property (
    status_o[1] |-> !status_o[0] && !status_o[2] && !$past(status_o[2]))
    else $error("ready with inhibit or locked");

  cover property (sequence_start_o);
  cover property (open_cmd_o);
  cover property (status_o[6]);
  cover property ($fell(status_o[2]));
endmodule

bind auto_reclose_general_control reclose_ctrl_asserts u_chk (
  .core_clk_i, .reset_i, .rd_i, .rd_data_o, .lock_input_i, .lock_reset_i,
  .any_close_cmd_i, .final_trip_i, .sequence_start_o, .open_cmd_o,
  .object_sel_o, .status_o, .timer_kind_o, .timer_value_o
);

`default_nettype wire

// ---- reclose_ctrl_pkg.sv ----
/*
  constants, register map and enumerations of the auto_reclose general control block.
  assumes a single 20 mhz core clock and a plain strobe register port.
*/
package reclose_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned STEP_US      = 5000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000000 * STEP_US;
  localparam int unsigned MAX_TIME_S   = 1800;
  localparam int unsigned MAX_COUNT    = MAX_TIME_S * 1000000 / STEP_US;
  localparam int unsigned TIME_W       = 19;
  localparam int unsigned RECLAIM_MS   = 10000;
  localparam logic [TIME_W-1:0] RECLAIM_RST = TIME_W'(RECLAIM_MS * 1000 / STEP_US);
  localparam logic [TIME_W-1:0] LOCKOUT_RST = '0;

  ////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR  = 8'h04;
  localparam logic [7:0] TVALUE_ADDR  = 8'h08;
  localparam logic [7:0] TKIND_ADDR   = 8'h0c;
  localparam logic [7:0] EVENT_ADDR   = 8'h10;
  localparam logic [7:0] MASK_ADDR    = 8'h14;
  localparam logic [3:0] GRP_BASE_HI  = 4'h2;
  localparam logic [1:0] GRP_CFG_SEL  = 2'h0;
  localparam logic [1:0] GRP_LOCK_SEL = 2'h1;
  localparam logic [1:0] GRP_RCLM_SEL = 2'h2;

  // control fields
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT  = 1;
  // group config fields
  localparam int unsigned CFG_EN_BIT    = 0;
  localparam int unsigned CFG_OBJ_LSB   = 1;
  localparam int unsigned CFG_OBJ_W     = 3;
  localparam int unsigned CFG_RST_BIT   = 4;
  localparam int unsigned CFG_GEN_BIT   = 5;
  localparam int unsigned CFG_W         = 6;
  localparam logic [CFG_W-1:0] CFG_RST  = '0;
  localparam int unsigned NUM_OBJ       = 5;

  // event bits
  localparam int unsigned EV_LOCKED  = 0;
  localparam int unsigned EV_SUCCESS = 1;
  localparam int unsigned EV_OPEN    = 2;
  localparam int unsigned EV_READY   = 3;
  localparam int unsigned EV_W       = 4;

  ////////////////////////////////////////////////////////////////////////
  // states and timer kinds
  typedef enum logic [2:0] {
    ST_INHIBIT = 3'b000,
    ST_READY   = 3'b001,
    ST_RUNNING = 3'b010,
    ST_LOCKOUT = 3'b011,
    ST_RECLAIM = 3'b100,
    ST_LOCKED  = 3'b101
  } state_t;

  typedef enum logic [2:0] {
    TK_NONE    = 3'b000,
    TK_LOCKOUT = 3'b001,
    TK_RESET   = 3'b010,
    TK_START   = 3'b011,
    TK_DEAD    = 3'b100,
    TK_DISCR   = 3'b101,
    TK_SHOT    = 3'b110
  } timer_kind_t;

endpackage

// ---- shot_engine_model.sv ----
/*
  shot engine model: runs one shot per start and reports success.
  assumes start pulses come from the control block.
*/
`timescale 1ns/100ps
`default_nettype none

module shot_engine_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // from control block (start) and bench (delay)
  input  wire logic        start_i,
  input  wire logic [7:0]  dly_i,
  // to control block
  output logic      [4:0]  shot_o,
  output logic             done_o,
  output logic             clr_o,
  output logic      [2:0]  kind_o,
  output logic      [18:0] val_o
);
  logic [7:0] cnt_q;

  assign shot_o = {4'h0, cnt_q != 8'h00};
  assign kind_o = (cnt_q != 8'h00) ? reclose_ctrl_pkg::TK_DEAD : reclose_ctrl_pkg::TK_NONE;
  assign val_o  = 19'(cnt_q);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_q  <= 8'h00;
      done_o <= 1'b0;
      clr_o  <= 1'b0;
    end else begin
      done_o <= cnt_q == 8'h01;
      clr_o  <= done_o;
      if (start_i) cnt_q <= dly_i;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

`default_nettype wire

// ---- testbench.sv ----
/*
  self-checking bench of auto_reclose_general_control.
  assumes the package, design, checker and shot engine model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int unsigned TK = 4;
  logic        core_clk_i      = 1'b0;
  logic        reset_i         = 1'b1;
  logic [7:0]  addr_i          = 8'h00;
  logic [31:0] wr_data_i       = 32'h0;
  logic        wr_i            = 1'b0;
  logic        rd_i            = 1'b0;
  logic [1:0]  setting_group_i = 2'h0;
  logic [4:0]  req             = 5'h00;
  logic [4:0]  pl              = 5'h00;
  logic [2:0]  lv              = 3'h0;
  logic [7:0]  dly             = 8'h03;
  logic [31:0] rng             = 32'hb77c;
  logic [31:0] rd_data_o, status_o;
  logic [18:0] timer_value_o, val;
  logic [4:0]  object_sel_o, shot;
  logic [2:0]  timer_kind_o, kind;
  logic        irq_o, sequence_start_o, open_cmd_o, done, clr;
  int          fails = 0, n_tests = 0, cyc = 0, n = 0, nst = 0, nop = 0, n5 = 0, k;

  initial forever #25 core_clk_i = ~core_clk_i;

  auto_reclose_general_control #(.TICK_CYCLES(TK), .NUM_GROUPS(4)) u_dut (
    .core_clk_i, .reset_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .irq_o,
    .setting_group_i, .reclose_enable_input_i(lv[0]), .block_i(lv[1]),
    .object_fault_i(lv[2]), .lock_input_i(pl[4]), .lock_reset_i(pl[0]),
    .manual_close_i(pl[1]), .any_close_cmd_i(pl[2]), .final_trip_i(pl[3]),
    .reclose_success_i(done), .reclose_request_i(req), .shot_running_i(shot),
    .shot_clear_i(clr), .shot_timer_kind_i(kind), .shot_timer_value_i(val),
    .sequence_start_o, .open_cmd_o, .object_sel_o, .status_o, .timer_kind_o,
    .timer_value_o
  );

  shot_engine_model u_shot (
    .core_clk_i, .reset_i, .start_i(sequence_start_o), .dly_i(dly), .shot_o(shot),
    .done_o(done), .clr_o(clr), .kind_o(kind), .val_o(val)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [7:0] ga(int g, int r);
    return 8'(32 + 16 * g + 4 * r);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic nx(int c);
    repeat (c) @(negedge core_clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk(rd_data_o, e);
  endtask
  task automatic pulse(int b);
    @(posedge core_clk_i);
    pl[b] <= 1'b1;
    @(posedge core_clk_i);
    pl[b] <= 1'b0;
  endtask
  task automatic rq(logic [4:0] r);
    @(posedge core_clk_i);
    req <= r;
    @(posedge core_clk_i);
    req <= 5'h00;
  endtask
  task automatic ws(int b, logic v);
    n = 0;
    @(negedge core_clk_i);
    while (status_o[b] !== v && n < 300) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(32'(status_o[b]), 32'(v));
  endtask

  always @(posedge core_clk_i) begin
    cyc++;
    if (sequence_start_o === 1'b1) nst++;
    if (open_cmd_o === 1'b1) nop++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  always @(negedge core_clk_i) if (status_o[5] === 1'b1) n5++;

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rng = xs(rng);
    dly <= 8'h03 + 8'(rng % 6);
    nx(2);
    chk(32'(object_sel_o), 32'h1);
    ws(0, 1'b1);
    rd(reclose_ctrl_pkg::CTRL_ADDR, 32'h0);
    rd(reclose_ctrl_pkg::TVALUE_ADDR, 32'h0);
    rd(reclose_ctrl_pkg::TKIND_ADDR, 32'h0);
    rd(ga(0, 0), 32'h0);
    rd(ga(0, 1), 32'h0);
    rd(ga(0, 2), 32'h7d0);
    rd(8'h18, 32'h0);
    rd(reclose_ctrl_pkg::STATUS_ADDR, 32'h11);
    wr(ga(0, 0), 32'h1);
    rq(5'h01);
    nx(4);
    chk(32'(nst), 32'h0);
    $display("test defaults done");
    wr(reclose_ctrl_pkg::CTRL_ADDR, 32'h1);
    ws(1, 1'b1);
    wr(reclose_ctrl_pkg::CTRL_ADDR, 32'h3);
    ws(0, 1'b1);
    @(posedge core_clk_i);
    lv[0] <= 1'b1;
    ws(1, 1'b1);
    wr(reclose_ctrl_pkg::CTRL_ADDR, 32'h1);
    $display("test enable done");
    @(posedge core_clk_i);
    setting_group_i <= 2'h1;
    for (k = 0; k < 6; k++) begin
      wr(ga(1, 0), 32'(1 + 2 * k));
      nx(2);
      chk(32'(object_sel_o), (k < 5) ? 32'h1 << k : 32'h1);
    end
    @(posedge core_clk_i);
    setting_group_i <= 2'h2;
    ws(0, 1'b1);
    @(posedge core_clk_i);
    setting_group_i <= 2'h0;
    ws(1, 1'b1);
    $display("test groups done");
    wr(ga(0, 1), 32'h3);
    rq(5'h01);
    ws(3, 1'b1);
    nx(2);
    chk(32'(status_o[16:12]), 32'h1);
    chk(32'(timer_kind_o), 32'(reclose_ctrl_pkg::TK_DEAD));
    ws(5, 1'b1);
    chk(32'(timer_value_o), 32'h3);
    chk(32'(timer_kind_o), 32'(reclose_ctrl_pkg::TK_LOCKOUT));
    chk(32'(status_o[18]), 32'h1);
    nx(1);
    chk(32'(status_o[17]), 32'h1);
    ws(1, 1'b1);
    chk(32'(n >= 7 && n <= 13), 32'h1);
    wr(ga(0, 1), 32'h0);
    k = n5;
    rq(5'h01);
    ws(3, 1'b1);
    ws(1, 1'b1);
    chk(32'(n5), 32'(k));
    $display("test lockout done");
    chk(32'(irq_o), 32'h0);
    wr(ga(0, 1), 32'h32);
    rq(5'h01);
    ws(5, 1'b1);
    rq(5'h02);
    ws(2, 1'b1);
    wr(reclose_ctrl_pkg::MASK_ADDR, 32'hf);
    chk(32'(nop), 32'h1);
    nx(2);
    chk(32'(irq_o), 32'h1);
    rd(reclose_ctrl_pkg::MASK_ADDR, 32'hf);
    rd(reclose_ctrl_pkg::EVENT_ADDR, 32'hf);
    wr(reclose_ctrl_pkg::EVENT_ADDR, 32'hf);
    nx(2);
    chk(32'(irq_o), 32'h0);
    pulse(2);
    nx(3);
    chk(32'(status_o[2]), 32'h1);
    pulse(0);
    ws(1, 1'b1);
    $display("test relock done");
    wr(ga(0, 2), 32'h5);
    pulse(1);
    ws(6, 1'b1);
    chk(32'(timer_value_o), 32'h5);
    chk(32'(timer_kind_o), 32'(reclose_ctrl_pkg::TK_RESET));
    k = nst;
    rq(5'h04);
    ws(2, 1'b1);
    chk(32'(nst), 32'(k));
    wr(ga(0, 0), 32'h11);
    pulse(2);
    ws(1, 1'b1);
    wr(ga(0, 0), 32'h21);
    rq(5'h01);
    ws(6, 1'b1);
    chk(32'(timer_kind_o), 32'(reclose_ctrl_pkg::TK_RESET));
    ws(1, 1'b1);
    wr(ga(0, 0), 32'h1);
    $display("test reclaim done");
    pulse(3);
    ws(2, 1'b1);
    for (k = 0; k < 4; k++) begin
      rng = xs(rng);
      @(posedge core_clk_i);
      req <= rng[4:0];
      nx(2);
      chk(32'(status_o[11:7]), 32'(rng[4:0]));
    end
    @(posedge core_clk_i);
    req <= 5'h00;
    pulse(0);
    ws(1, 1'b1);
    @(posedge core_clk_i);
    lv[1] <= 1'b1;
    ws(0, 1'b1);
    @(posedge core_clk_i);
    lv[2] <= 1'b1;
    @(posedge core_clk_i);
    lv[1] <= 1'b0;
    nx(3);
    chk(32'(status_o[0]), 32'h1);
    @(posedge core_clk_i);
    lv[2] <= 1'b0;
    ws(1, 1'b1);
    pulse(4);
    ws(2, 1'b1);
    pulse(0);
    ws(1, 1'b1);
    $display("test inhibit done");
    wr(ga(0, 1), 32'h32);
    rq(5'h01);
    ws(5, 1'b1);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    ws(0, 1'b1);
    chk(32'(timer_value_o), 32'h0);
    rd(reclose_ctrl_pkg::CTRL_ADDR, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule

`default_nettype wire
